// ===== core/lvd_params.svh
`ifndef LVD_PARAMS_SVH
`define LVD_PARAMS_SVH

// Register byte addresses on the bus
`define LVD_ADDR_CTRL      4'h0
`define LVD_ADDR_IRQ       4'h4
`define LVD_ADDR_OPT       4'h8

// Control register fields
`define LVD_CTRL_STATUS    7
`define LVD_CTRL_FLAG      6
`define LVD_CTRL_WAKE      0

// Interrupt enable, detector on and detect level register fields
`define LVD_IRQ_IE         7
`define LVD_IRQ_ON         6
`define LVD_IRQ_LVL_HI     5
`define LVD_IRQ_LVL_LO     4

// Option view register fields
`define LVD_OPTV_SYSRST    3
`define LVD_OPTV_HALT      2
`define LVD_OPTV_LVR_HI    1
`define LVD_OPTV_LVR_LO    0

// Non-volatile option word
`define LVD_OPT_W          13
`define LVD_OPT_LVR_HI     9
`define LVD_OPT_LVR_LO     8
`define LVD_LVR_OFF        2'h3

// Reset values
`define LVD_LVL_RST        2'h0
`define LVD_LVR_RST        2'h3

// Timing
`define LVD_CLK_PERIOD_NS  100
`define LVD_BROWNOUT_NS    80000
`define LVD_BROWNOUT_CYC   ((`LVD_BROWNOUT_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)
`define LVD_RST_PULSE_CYC  16
`define LVD_CNT_W          16

`endif

// ===== core/lvd_pkg.sv
`default_nettype none
`include "lvd_params.svh"

package lvd_pkg;

   typedef enum logic [2:0] {
      BO_RUN   = 3'b001,
      BO_HALT  = 3'b010,
      BO_RESET = 3'b100
   } lvd_bo_e;

   typedef struct packed {
      lvd_bo_e                bo;
      logic [`LVD_CNT_W-1:0]  cnt;
      logic [1:0]             lvr_sel;
      logic                   opt_valid;
      logic                   wake_en;
      logic                   irq_en;
      logic                   det_on;
      logic [1:0]             lvl;
      logic                   flag;
      logic                   gie;
      logic                   low_prev;
      logic                   waitreq;
      logic [7:0]             rdata;
      logic                   irq;
      logic                   wake;
      logic                   halt;
      logic                   sys_rst;
   } lvd_state_s;

endpackage

`default_nettype wire

// ===== core/lvd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module lvd_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_in,  // Core clock
   input  wire logic             rst_b_in,  // Async reset, active low
   input  wire logic [WIDTH-1:0] async_in,  // Comparator levels
   output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // lvd_sync

`default_nettype wire

// ===== core/lvd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvd_params.svh"

module lvd_top
   import lvd_pkg::*;
#(
   parameter int BO_CYC    = `LVD_BROWNOUT_CYC,
   parameter int PULSE_CYC = `LVD_RST_PULSE_CYC
) (
   input  wire logic                 clock_in,          // Core clock, 10 MHz
   input  wire logic                 rst_b_in,          // Async reset, active low
   input  wire logic [3:0]           address_in,        // Avalon byte address
   input  wire logic                 read_in,           // Avalon read
   input  wire logic                 write_in,          // Avalon write
   input  wire logic [31:0]          writedata_in,      // Avalon write data
   input  wire logic [3:0]           byteenable_in,     // Avalon byte enables
   output logic      [31:0]          readdata_out,      // Avalon read data
   output logic                      waitrequest_out,   // Avalon wait request
   input  wire logic [`LVD_OPT_W-1:0] option_word_in,   // Non-volatile option word
   input  wire logic [3:0]           det_below_in,      // Supply at/below detect level n
   input  wire logic [2:0]           rst_below_in,      // Supply below reset level n
   input  wire logic                 global_irq_on_in,  // Enable-interrupts executed
   input  wire logic                 global_irq_off_in, // Disable-interrupts executed
   output logic                      irq_out,           // Detector interrupt to core
   output logic                      wake_out,          // Wake-up request
   output logic                      halt_out,          // Core halted, clock runs
   output logic                      sys_reset_out      // Full system reset
);

   lvd_state_s s_q;
   lvd_state_s s_d;
   logic [6:0] sync_lv;
   logic [3:0] det_s;
   logic [3:0] rst_s;
   logic       low_now;
   logic       crossing;
   logic       rst_low;
   logic       wr_acc;
   logic       wr_ctrl;
   logic       wr_irq;

   // Comparators are asynchronous to the core clock
   lvd_sync #(.WIDTH(7)) u_sync (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .async_in ({rst_below_in, det_below_in}),
      .sync_out (sync_lv)
   );

   assign det_s = sync_lv[3:0];
   assign rst_s = {1'b0, sync_lv[6:4]};

   always_comb begin
      s_d = s_q;

      // Option field is a strap: caught once after reset release
      if (!s_q.opt_valid) begin
         s_d.lvr_sel   = option_word_in[`LVD_OPT_LVR_HI:`LVD_OPT_LVR_LO];
         s_d.opt_valid = 1'b1;
      end

      low_now  = s_q.det_on & det_s[s_q.lvl];
      crossing = low_now & ~s_q.low_prev;
      s_d.low_prev = low_now;
      rst_low  = (s_q.lvr_sel != `LVD_LVR_OFF) & rst_s[s_q.lvr_sel];

      // Bus slave: one wait state, answer on the following edge
      s_d.waitreq = 1'b1;
      wr_acc  = write_in & ~s_q.waitreq & byteenable_in[0];
      wr_ctrl = wr_acc & (address_in == `LVD_ADDR_CTRL);
      wr_irq  = wr_acc & (address_in == `LVD_ADDR_IRQ);
      if ((read_in | write_in) & s_q.waitreq) begin
         s_d.waitreq = 1'b0;
         unique case (address_in)
            `LVD_ADDR_CTRL: begin
               s_d.rdata = 8'h00;
               s_d.rdata[`LVD_CTRL_STATUS] = ~low_now;
               s_d.rdata[`LVD_CTRL_FLAG]   = s_q.flag;
               s_d.rdata[`LVD_CTRL_WAKE]   = s_q.wake_en;
            end
            `LVD_ADDR_IRQ: begin
               s_d.rdata = 8'h00;
               s_d.rdata[`LVD_IRQ_IE] = s_q.irq_en;
               s_d.rdata[`LVD_IRQ_ON] = s_q.det_on;
               s_d.rdata[`LVD_IRQ_LVL_HI:`LVD_IRQ_LVL_LO] = s_q.lvl;
            end
            `LVD_ADDR_OPT: begin
               s_d.rdata = 8'h00;
               s_d.rdata[`LVD_OPTV_SYSRST] = s_q.sys_rst;
               s_d.rdata[`LVD_OPTV_HALT]   = s_q.halt;
               s_d.rdata[`LVD_OPTV_LVR_HI:`LVD_OPTV_LVR_LO] = s_q.lvr_sel;
            end
            default: s_d.rdata = 8'h00;
         endcase
      end

      if (wr_ctrl) begin
         s_d.wake_en = writedata_in[`LVD_CTRL_WAKE];
         // Writing 0 clears; writing 1 cannot fake an event
         if (!writedata_in[`LVD_CTRL_FLAG]) begin
            s_d.flag = 1'b0;
         end
      end
      if (wr_irq) begin
         s_d.irq_en = writedata_in[`LVD_IRQ_IE];
         s_d.det_on = writedata_in[`LVD_IRQ_ON];
         s_d.lvl    = writedata_in[`LVD_IRQ_LVL_HI:`LVD_IRQ_LVL_LO];
      end

      // Set beats clear in the same cycle; no sleep gating here
      if (crossing) begin
         s_d.flag = 1'b1;
      end

      if (global_irq_on_in) begin
         s_d.gie = 1'b1;
      end
      if (global_irq_off_in) begin
         s_d.gie = 1'b0;
      end

      // Brown-out timing on the always-running core clock
      unique case (s_q.bo)
         BO_RUN: begin
            s_d.cnt = '0;
            if (rst_low) begin
               s_d.bo   = BO_HALT;
               s_d.halt = 1'b1;
            end
         end
         BO_HALT: begin
            if (!rst_low) begin
               s_d.bo   = BO_RUN;
               s_d.cnt  = '0;
               s_d.halt = 1'b0;
            end else if (s_q.cnt == `LVD_CNT_W'(BO_CYC - 1)) begin
               s_d.bo      = BO_RESET;
               s_d.cnt     = '0;
               s_d.sys_rst = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + `LVD_CNT_W'(1);
            end
         end
         BO_RESET: begin
            if (s_q.cnt != `LVD_CNT_W'(PULSE_CYC - 1)) begin
               s_d.cnt = s_q.cnt + `LVD_CNT_W'(1);
            end else if (!rst_low) begin
               s_d.bo      = BO_RUN;
               s_d.cnt     = '0;
               s_d.sys_rst = 1'b0;
               s_d.halt    = 1'b0;
            end
         end
         default: begin
            s_d.bo = BO_RUN;
         end
      endcase

      // The reset this block issues clears its control and interrupt fields and gie too; lvr_sel keeps its value
      if (s_q.bo == BO_RESET) begin
         s_d.flag    = 1'b0;
         s_d.wake_en = 1'b0;
         s_d.irq_en  = 1'b0;
         s_d.det_on  = 1'b0;
         s_d.lvl     = `LVD_LVL_RST;
         s_d.gie     = 1'b0;
      end

      s_d.irq  = s_d.flag & s_d.irq_en & s_d.gie;
      s_d.wake = s_d.flag & s_d.wake_en;
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q           <= '0;
         s_q.bo        <= BO_RUN;
         s_q.lvr_sel   <= `LVD_LVR_RST;
         s_q.lvl       <= `LVD_LVL_RST;
         s_q.waitreq   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata_out    = {24'h000000, s_q.rdata};
   assign waitrequest_out = s_q.waitreq;
   assign irq_out         = s_q.irq;
   assign wake_out        = s_q.wake;
   assign halt_out        = s_q.halt;
   assign sys_reset_out   = s_q.sys_rst;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   a_status_off_read: assert property (
      (read_in && s_q.waitreq && address_in == `LVD_ADDR_CTRL && !s_q.det_on)
      |=> readdata_out[`LVD_CTRL_STATUS])
      else $error("status bit low while detector off");

   a_status_low_read: assert property (
      (read_in && s_q.waitreq && address_in == `LVD_ADDR_CTRL && low_now)
      |=> !readdata_out[`LVD_CTRL_STATUS] && !waitrequest_out)
      else $error("status bit high while supply low");

   a_flag_on_cross: assert property (
      (crossing && s_q.bo != BO_RESET) |=> s_q.flag ##1 (s_q.flag || $past(wr_ctrl) || s_q.bo == BO_RESET))
      else $error("crossing did not set flag");

   a_flag_sw_clear: assert property (
      (wr_ctrl && !writedata_in[`LVD_CTRL_FLAG] && !crossing) |=> !s_q.flag)
      else $error("software clear of flag lost");

   a_flag_reset_clr: assert property (
      (s_q.bo == BO_RESET) |=> !s_q.flag && !irq_out)
      else $error("flag survives system reset");

   a_irq_gating: assert property (
      irq_out == (s_q.flag && s_q.irq_en && s_q.gie))
      else $error("interrupt without enables");

   a_bo_reset_time: assert property (
      $rose(sys_reset_out) |-> $past(s_q.bo) == BO_HALT && $past(halt_out)
      && $past(s_q.cnt) == `LVD_CNT_W'(BO_CYC - 1))
      else $error("system reset not at brown-out limit");

   a_short_dip: assert property (
      (s_q.bo == BO_HALT && !rst_low) |=> !halt_out && !sys_reset_out && s_q.cnt == '0)
      else $error("short dip not released");

   a_wait_single: assert property (
      ((read_in || write_in) && waitrequest_out) |=> !waitrequest_out ##1 waitrequest_out)
      else $error("wait request not single cycle");

   c_flag_set:   cover property (crossing ##1 irq_out);
   c_short_dip:  cover property ($rose(halt_out) ##[1:20] $fell(halt_out));
   c_long_dip:   cover property ($rose(sys_reset_out));
   c_wake:       cover property ($rose(wake_out));

endmodule // lvd_top

`default_nettype wire

// ===== core/lvd_top_unused_note_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verif/lvd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvd_params.svh"

module tb;
   localparam int BO = 10;
   localparam int PL = 4;
   logic        clock_in, rst_b_in, read_in, write_in, waitrequest_out;
   logic        global_irq_on_in, global_irq_off_in, irq_out, wake_out, halt_out, sys_reset_out;
   logic [3:0]  address_in, byteenable_in, det_below_in;
   logic [2:0]  rst_below_in;
   logic [31:0] writedata_in, readdata_out, r;
   logic [`LVD_OPT_W-1:0] option_word_in;
   int          n_fail, check_count, ie, gie, d, n;
   int          m_det, m_lvl, m_on, m_ie, m_gie, m_wake, m_flag;

   lvd_top #(.BO_CYC(BO), .PULSE_CYC(PL)) dut_u (
      .clock_in(clock_in), .rst_b_in(rst_b_in), .address_in(address_in), .read_in(read_in),
      .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
      .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .option_word_in(option_word_in),
      .det_below_in(det_below_in), .rst_below_in(rst_below_in), .global_irq_on_in(global_irq_on_in),
      .global_irq_off_in(global_irq_off_in), .irq_out(irq_out), .wake_out(wake_out),
      .halt_out(halt_out), .sys_reset_out(sys_reset_out));

   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Request held until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] dat, input logic [3:0] be);
      int k;
      k = 0;
      @(posedge clock_in);
      address_in    <= a;
      write_in      <= w;
      read_in       <= !w;
      writedata_in  <= {24'h0, dat};
      byteenable_in <= be;
      do begin
         @(posedge clock_in);
         k++;
      end while (waitrequest_out !== 1'b0);
      r = readdata_out;
      read_in  <= 1'b0;
      write_in <= 1'b0;
      // One wait state: answer sampled on the second edge
      check("wait edges", k, 2);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00, 4'hF);
      check("readdata", r, exp);
   endtask

   // Register model, written from the rules
   function automatic logic m_low();
      return m_on != 0 && m_det[m_lvl] == 1'b1;
   endfunction

   function automatic logic [31:0] m_ctrl();
      return {24'h000000, !m_low(), m_flag[0], 5'h00, m_wake[0]};
   endfunction

   function automatic logic [31:0] m_irq();
      return {24'h000000, m_ie[0], m_on[0], m_lvl[1:0], 4'h0};
   endfunction

   task automatic m_clear();
      m_lvl  = 0;
      m_on   = 0;
      m_ie   = 0;
      m_gie  = 0;
      m_wake = 0;
      m_flag = 0;
   endtask

   // Bus write that the model follows; entering the low state sets the flag
   task automatic mwr(input logic [3:0] a, input logic [7:0] dat);
      logic pl;
      pl = m_low();
      bus(1'b1, a, dat, 4'hF);
      if (a == `LVD_ADDR_CTRL) begin
         m_wake = dat[`LVD_CTRL_WAKE];
         if (!dat[`LVD_CTRL_FLAG]) begin
            m_flag = 0;
         end
      end else if (a == `LVD_ADDR_IRQ) begin
         m_ie  = dat[`LVD_IRQ_IE];
         m_on  = dat[`LVD_IRQ_ON];
         m_lvl = dat[`LVD_IRQ_LVL_HI:`LVD_IRQ_LVL_LO];
      end
      if (m_low() && !pl) begin
         m_flag = 1;
      end
   endtask

   task automatic set_det(input logic [3:0] v);
      logic pl;
      pl = m_low();
      det_below_in <= v;
      m_det = v;
      if (m_low() && !pl) begin
         m_flag = 1;
      end
   endtask

   task automatic do_reset(input logic [1:0] sel, input int cyc);
      logic [`LVD_OPT_W-1:0] ow;
      m_clear();
      ow = `LVD_OPT_W'($urandom);
      ow[`LVD_OPT_LVR_HI:`LVD_OPT_LVR_LO] = sel;
      @(posedge clock_in);
      rst_b_in       <= 1'b0;
      option_word_in <= ow;
      repeat (cyc) @(posedge clock_in);
      rst_b_in <= 1'b1;
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(100 * 30000);
      n_fail++;
      finish_test();
   end

   initial begin
      void'($urandom(12756));
      {read_in, write_in, global_irq_on_in, global_irq_off_in} = 4'h0;
      {address_in, byteenable_in, det_below_in, rst_below_in} = 15'h0;
      writedata_in   = 32'h0;
      rst_b_in       = 1'b0;
      option_word_in = 13'h0;
      do_reset(2'h0, 16);
      rd(`LVD_ADDR_CTRL, 32'h80);
      rd(`LVD_ADDR_IRQ, 32'h00);
      rd(4'hC, 32'h0);
      for (int l = 0; l < 4; l++) begin
         ie = $urandom % 2;
         gie = (l % 2 == 0);
         d = (ie << 7) | 8'h40 | (l << 4);
         mwr(`LVD_ADDR_IRQ, d[7:0] & 8'h30);
         mwr(`LVD_ADDR_CTRL, 8'h41);
         mwr(`LVD_ADDR_IRQ, d[7:0] & 8'hB0);
         @(posedge clock_in);
         global_irq_on_in  <= gie;
         global_irq_off_in <= !gie;
         m_gie = gie;
         @(posedge clock_in);
         {global_irq_on_in, global_irq_off_in} <= 2'h0;
         mwr(`LVD_ADDR_IRQ, d[7:0]);
         bus(1'b1, `LVD_ADDR_IRQ, 8'h00, 4'h0);
         rd(`LVD_ADDR_IRQ, m_irq());
         set_det((4'h1 << l) - 4'h1);
         repeat (6) @(posedge clock_in);
         rd(`LVD_ADDR_CTRL, m_ctrl());
         set_det((4'h2 << l) - 4'h1);
         repeat (6) @(posedge clock_in);
         rd(`LVD_ADDR_CTRL, m_ctrl());
         check("irq", irq_out, m_flag & m_ie & m_gie);
         check("wake", wake_out, m_flag & m_wake);
         mwr(`LVD_ADDR_CTRL, 8'h00);
         rd(`LVD_ADDR_CTRL, m_ctrl());
         check("wake", wake_out, m_flag & m_wake);
         mwr(`LVD_ADDR_IRQ, d[7:0] & 8'hBF);
         rd(`LVD_ADDR_CTRL, m_ctrl());
         set_det(4'h0);
      end
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1:0], 2);
         rd(`LVD_ADDR_OPT, s);
         mwr(`LVD_ADDR_IRQ, 8'hC0);
         set_det(4'h1);
         repeat (6) @(posedge clock_in);
         rd(`LVD_ADDR_CTRL, m_ctrl());
         rst_below_in <= (s == 3) ? 3'h7 : (3'h1 << s) - 3'h1;
         repeat (6) @(posedge clock_in);
         check("halt", halt_out, 0);
         if (s < 3) begin
            rst_below_in <= (3'h2 << s) - 3'h1;
            repeat (4) @(posedge clock_in);
            check("halt", halt_out, 1);
            repeat (BO - 6) @(posedge clock_in);
            check("sysrst", sys_reset_out, 0);
            rst_below_in <= (3'h1 << s) - 3'h1;
            repeat (5) @(posedge clock_in);
            check("halt", halt_out, 0);
            rd(`LVD_ADDR_CTRL, m_ctrl());
            rst_below_in <= (3'h2 << s) - 3'h1;
            repeat (BO - 2) @(posedge clock_in);
            check("sysrst", sys_reset_out, 0);
            n = 0;
            while (sys_reset_out !== 1'b1 && n < 20) begin
               @(posedge clock_in);
               n++;
            end
            check("sysrst", sys_reset_out, 1);
            // Internal system reset clears every control and interrupt register bit except the status bit, which reads 1; the option view keeps lvr_sel
            m_clear();
            rst_below_in <= 3'h0;
            repeat (PL + 12) @(posedge clock_in);
            check("sysrst", {halt_out, sys_reset_out}, 0);
            rd(`LVD_ADDR_CTRL, m_ctrl());
            rd(`LVD_ADDR_IRQ, m_irq());
         end
         rst_below_in <= 3'h0;
         set_det(4'h0);
      end
      finish_test();
   end
endmodule // tb

`default_nettype wire
